// file: logic/sdaa_pkg.sv
// Shared data array access: constants and types.
// Assumes a single 125 MHz clock domain.
package sdaa_pkg;
    localparam int unsigned SDAA_RECORDS = 800;
    localparam int unsigned SDAA_DATA_W = 32;
    localparam int unsigned SDAA_ADDR_W = 10;
    localparam logic [SDAA_ADDR_W-1:0] SDAA_ADDR_MAX = 10'h31F;
    localparam logic [15:0] SDAA_BACKUP_ARM = 16'h001E;
    localparam logic [15:0] SDAA_BACKUP_GO = 16'h0023;
    localparam logic [7:0] SDAA_MON_CAPACITY = 8'h6D;
    localparam logic [SDAA_ADDR_W-1:0] SDAA_INDEX_RST = 10'h000;

    typedef enum logic [2:0] {
        SDAA_ST_IDLE = 3'b001,
        SDAA_ST_ARMED = 3'b010,
        SDAA_ST_SET = 3'b100
    } sdaa_bk_t;
endpackage

// file: logic/sdaa_nv_if.sv
// Link between the access logic and the nonvolatile copy engine.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface sdaa_nv_if;
    logic restore_req;
    logic restore_busy;
    logic [9:0] restore_addr;
    logic restore_we;
    logic [31:0] restore_data;
    logic [9:0] save_addr;
    logic save_we;
    logic [31:0] save_data;
    logic [31:0] rd_data;
    modport ctrl (output restore_req, output rd_data,
                  input restore_busy, input restore_addr, input restore_we,
                  input restore_data, input save_addr, input save_we,
                  input save_data);
    modport eng (input restore_req, input rd_data,
                 output restore_busy, output restore_addr, output restore_we,
                 output restore_data, output save_addr, output save_we,
                 output save_data);
endinterface

// file: logic/sdaa_nv_engine.sv
// Copies the array to and from the nonvolatile store.
// Assumes the store answers reads in the same cycle and that a save walk
// is started by power-down and runs while the clock still ticks.
`timescale 1ns/1ps
module sdaa_nv_engine
    import sdaa_pkg::*;
(
    // Clock and reset
    input wire logic mclk_in,
    input wire logic nrst_in,
    // Save request
    input wire logic save_go_in,
    // Nonvolatile store pins
    input wire logic [31:0] nv_rdata_in,
    output logic [9:0] nv_addr_out,
    output logic nv_we_out,
    output logic [31:0] nv_wdata_out,
    // Access logic side
    sdaa_nv_if.eng nv
);
    typedef struct packed {
        logic busy;
        logic saving;
        logic [9:0] addr;
    } sdaa_eng_t;
    sdaa_eng_t s_reg, s_next;

    always_comb begin
        s_next = s_reg;
        if (!s_reg.busy && (nv.restore_req || save_go_in)) begin
            s_next.busy = 1'b1;
            s_next.saving = !nv.restore_req;
            s_next.addr = '0;
        end else if (s_reg.busy) begin
            if (s_reg.addr == SDAA_ADDR_MAX) begin
                s_next.busy = 1'b0;
            end else begin
                s_next.addr = s_reg.addr + 10'h001;
            end
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!nrst_in) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign nv.restore_busy = s_reg.busy && !s_reg.saving;
    assign nv.restore_addr = s_reg.addr;
    assign nv.restore_we = s_reg.busy && !s_reg.saving;
    assign nv.restore_data = nv_rdata_in;
    assign nv.save_addr = s_reg.addr;
    assign nv.save_we = s_reg.busy && s_reg.saving;
    assign nv.save_data = nv.rd_data;
    assign nv_addr_out = s_reg.addr;
    assign nv_we_out = s_reg.busy && s_reg.saving;
    assign nv_wdata_out = nv.rd_data;
endmodule

// file: logic/sdaa_top.sv
// Shared data array of 32-bit records reached through index and windows.
// Assumes access strobes are single-cycle pulses from same-clock logic;
// power_fail_in comes from a pin and is synchronised here.
`timescale 1ns/1ps

module sdaa_top
    import sdaa_pkg::*;
#(
    parameter int unsigned RECORDS = SDAA_RECORDS
)
(
    // Clock and reset
    input wire logic mclk_in,
    input wire logic nrst_in,
    // Parameter access strobes (same clock); power_fail_in is asynchronous
    input wire logic idx_wr_in,
    input wire logic win1_wr_in,
    input wire logic win1_rd_in,
    input wire logic win2_wr_in,
    input wire logic win2_rd_in,
    input wire logic from_keypad_in,
    input wire logic [31:0] wdata_in,
    input wire logic bk_wr_in,
    input wire logic [15:0] bk_data_in,
    input wire logic mon_rd_in,
    input wire logic [7:0] mon_code_in,
    input wire logic power_fail_in,
    // Nonvolatile store
    input wire logic [31:0] nv_rdata_in,
    output logic [9:0] nv_addr_out,
    output logic nv_we_out,
    output logic [31:0] nv_wdata_out,
    // Answers
    output logic [31:0] rdata_out,
    output logic rvalid_out,
    output logic reject_out,
    output logic [9:0] index_out,
    output logic [31:0] capacity_out,
    output logic [31:0] mon_data_out,
    output logic backup_armed_out,
    output logic restore_busy_out
);
    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [9:0] index;
        sdaa_bk_t bk;
        logic pf_s1;
        logic pf_s2;
        logic pf_d;
        logic boot;
        logic [31:0] rdata;
        logic rvalid;
        logic reject;
        logic [31:0] mon;
    } sdaa_st_t;
    sdaa_st_t s_reg, s_next;

    // ------------------------------------------------------------------
    // Array and store link
    // ------------------------------------------------------------------
    // One flat array serves every function; overlapping regions are the
    // user's business, so no address is reserved for any of them.
    logic [31:0] mem [0:SDAA_RECORDS-1];
    sdaa_nv_if nv();

    logic acc_rd, acc_wr, acc, in_range, bump, refuse;
    logic [31:0] mem_q;
    logic save_go;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic sdaa_valid(input logic [9:0] a);
        return a <= SDAA_ADDR_MAX;
    endfunction

    // ------------------------------------------------------------------
    // Access decode
    // ------------------------------------------------------------------
    always_comb begin
        refuse = win2_wr_in && from_keypad_in;
        acc_rd = win1_rd_in || win2_rd_in;
        acc_wr = win1_wr_in || (win2_wr_in && !from_keypad_in);
        acc = acc_rd || acc_wr;
        in_range = sdaa_valid(s_reg.index);
        // Keypad reads of window one leave the index alone.
        bump = acc && in_range && !(win1_rd_in && from_keypad_in);
    end

    assign mem_q = mem[nv.restore_busy ? nv.save_addr :
                       (in_range ? s_reg.index : 10'h000)];
    assign nv.rd_data = mem[nv.save_addr];
    // The save starts on the rising edge of the synchronised pin only, so
    // a pin that stays high cannot restart the walk over and over.
    assign save_go = s_reg.pf_s2 && !s_reg.pf_d &&
                     (s_reg.bk == SDAA_ST_SET);

    // The array only changes through window writes or the restore walk.
    always_ff @(posedge mclk_in) begin
        if (nv.restore_we) begin
            mem[nv.restore_addr] <= nv.restore_data;
        end else if (acc_wr && in_range && !s_reg.boot) begin
            mem[s_reg.index] <= wdata_in;
        end
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        s_next = s_reg;
        s_next.pf_s1 = power_fail_in;
        s_next.pf_s2 = s_reg.pf_s1;
        s_next.pf_d = s_reg.pf_s2;
        s_next.rvalid = 1'b0;
        s_next.reject = 1'b0;
        // Boot ends with the last record of the reload, not when the engine
        // looks idle: the engine is still idle at the first edge after reset.
        if (s_reg.boot && nv.restore_we &&
            (nv.restore_addr == SDAA_ADDR_MAX)) begin
            s_next.boot = 1'b0;
        end
        if (idx_wr_in) begin
            s_next.index = wdata_in[9:0];
        end else if (!s_reg.boot && bump) begin
            s_next.index = s_reg.index + 10'h001;
        end
        if (!s_reg.boot && acc_rd && in_range) begin
            s_next.rdata = mem_q;
            s_next.rvalid = 1'b1;
        end
        if (refuse || (acc && (!in_range || s_reg.boot))) begin
            s_next.reject = 1'b1;
        end
        // Only the exact pair arms the save; any other value falls back to
        // idle so that a stray write cannot leave a half-armed request.
        if (bk_wr_in) begin
            unique case (s_reg.bk)
                SDAA_ST_ARMED: s_next.bk = (bk_data_in == SDAA_BACKUP_GO) ?
                    SDAA_ST_SET : SDAA_ST_IDLE;
                default: s_next.bk = (bk_data_in == SDAA_BACKUP_ARM) ?
                    SDAA_ST_ARMED : SDAA_ST_IDLE;
            endcase
        end
        if (mon_rd_in) begin
            s_next.mon = (mon_code_in == SDAA_MON_CAPACITY) ?
                32'(RECORDS) : 32'h0000_0000;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!nrst_in) begin
            s_reg <= '0;
            s_reg.bk <= SDAA_ST_IDLE;
            s_reg.boot <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    // ------------------------------------------------------------------
    // Reload and save
    // ------------------------------------------------------------------
    // The reload is asked for once, at the first edge after reset; boot
    // and the engine's busy flag then fall together after the last record.
    assign nv.restore_req = s_reg.boot && !nv.restore_busy;

    sdaa_nv_engine u_eng (
        .mclk_in(mclk_in),
        .nrst_in(nrst_in),
        .save_go_in(save_go),
        .nv_rdata_in(nv_rdata_in),
        .nv_addr_out(nv_addr_out),
        .nv_we_out(nv_we_out),
        .nv_wdata_out(nv_wdata_out),
        .nv(nv)
    );

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign rdata_out = s_reg.rdata;
    assign rvalid_out = s_reg.rvalid;
    assign reject_out = s_reg.reject;
    assign index_out = s_reg.index;
    assign capacity_out = 32'(RECORDS);
    assign mon_data_out = s_reg.mon;
    assign backup_armed_out = (s_reg.bk == SDAA_ST_SET);
    assign restore_busy_out = s_reg.boot;
endmodule

// file: verif/sdaa_props.sv
// Port checker for the shared data array access block.
// Assumes it is bound to sdaa_top and sees only that module's ports.
`timescale 1ns/1ps
module sdaa_props
    import sdaa_pkg::*;
(
    input wire logic mclk_in, nrst_in, idx_wr_in, win1_wr_in, win1_rd_in,
    input wire logic win2_wr_in, win2_rd_in, from_keypad_in, bk_wr_in,
    input wire logic mon_rd_in, rvalid_out, reject_out, backup_armed_out,
    input wire logic restore_busy_out,
    input wire logic [31:0] wdata_in, capacity_out, mon_data_out,
    input wire logic [15:0] bk_data_in,
    input wire logic [7:0] mon_code_in,
    input wire logic [9:0] index_out
);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!nrst_in);
    logic ok, any_win;
    logic [9:0] wlo;
    assign ok = !restore_busy_out && index_out <= SDAA_ADDR_MAX;
    assign any_win = win1_wr_in || win1_rd_in || win2_wr_in || win2_rd_in;
    assign wlo = wdata_in[9:0];
    AST_CAP: assert property (capacity_out == SDAA_RECORDS)
        else $error("capacity value wrong");
    AST_IDX: assert property (idx_wr_in && !restore_busy_out
        |=> index_out == $past(wlo)) else $error("index not loaded");
    AST_W1K: assert property (win1_rd_in && from_keypad_in && ok
        |=> rvalid_out && index_out == $past(index_out))
        else $error("keypad read moved index");
    AST_INC: assert property ((win1_wr_in || win2_rd_in ||
        ((win1_rd_in || win2_wr_in) && !from_keypad_in)) && ok
        |=> index_out == $past(index_out) + 10'h001)
        else $error("index not incremented");
    AST_W2K: assert property (win2_wr_in && from_keypad_in
        |=> reject_out && $stable(index_out))
        else $error("keypad write to window two taken");
    AST_OOR: assert property (any_win && index_out > SDAA_ADDR_MAX
        |=> reject_out && !rvalid_out && $stable(index_out))
        else $error("out of range access taken");
    AST_MON: assert property (mon_rd_in |=> mon_data_out ==
        (($past(mon_code_in) == SDAA_MON_CAPACITY) ? SDAA_RECORDS : 0))
        else $error("monitor value wrong");
    AST_ARM: assert property ($rose(backup_armed_out) |->
        $past(bk_wr_in) && $past(bk_data_in) == SDAA_BACKUP_GO)
        else $error("backup armed without second value");
    AST_RST: assert property (restore_busy_out |->
        ##[0:900] !restore_busy_out) else $error("reload never ends");
endmodule

bind sdaa_top sdaa_props u_props (.mclk_in, .nrst_in, .idx_wr_in,
    .win1_wr_in, .win1_rd_in, .win2_wr_in, .win2_rd_in, .from_keypad_in,
    .bk_wr_in, .mon_rd_in, .rvalid_out, .reject_out, .backup_armed_out,
    .restore_busy_out, .wdata_in, .capacity_out, .mon_data_out,
    .bk_data_in, .mon_code_in, .index_out);

// file: verif/sdaa_nv_model.sv
// Behavioural nonvolatile store on the block's store pins.
// Assumes reads answer in the same cycle and writes land on the clock.
`timescale 1ns/1ps
module sdaa_nv_model
    import sdaa_pkg::*;
(
    input wire logic mclk_in,
    input wire logic [9:0] nv_addr_in,
    input wire logic nv_we_in,
    input wire logic [31:0] nv_wdata_in,
    output logic [31:0] nv_rdata_out
);
    logic [31:0] mem [SDAA_RECORDS];
    // A fixed pattern stands for data kept from an earlier power cycle.
    initial begin
        for (int i = 0; i < SDAA_RECORDS; i++) begin
            mem[i] = 32'h5A00_0000 + i;
        end
    end
    // No cell exists past the array, so the bus shows a moving pattern.
    assign nv_rdata_out = (nv_addr_in <= SDAA_ADDR_MAX) ?
        mem[nv_addr_in] : {22'h3F_FFFF, ~nv_addr_in};
    always @(posedge mclk_in) begin
        if (nv_we_in && nv_addr_in <= SDAA_ADDR_MAX) begin
            mem[nv_addr_in] <= nv_wdata_in;
        end
    end
endmodule

// file: verif/tb.sv
// Self-checking bench for the shared data array access block.
// Assumes the store model sits on the store pins of the top module.
`timescale 1ns/1ps
module tb;
    import sdaa_pkg::*;
    logic mclk_in = 0, nrst_in = 0, from_keypad_in = 0, power_fail_in = 0;
    logic idx_wr_in = 0, win1_wr_in = 0, win1_rd_in = 0, win2_wr_in = 0;
    logic win2_rd_in = 0, bk_wr_in = 0, mon_rd_in = 0;
    logic [31:0] wdata_in = '0, d, nv_rdata_in, rdata_out, nv_wdata_out;
    logic [31:0] capacity_out, mon_data_out;
    logic [15:0] bk_data_in = '0;
    logic [7:0] mon_code_in = '0;
    logic [9:0] nv_addr_out, index_out, exp_idx = '0;
    logic nv_we_out, rvalid_out, reject_out, backup_armed_out;
    logic restore_busy_out;
    logic [31:0] exp_mem [SDAA_RECORDS];
    int mismatches = 0, cmp_count = 0, seed = 75171, n;
    always #4 mclk_in = ~mclk_in;
    sdaa_top dut (.mclk_in, .nrst_in, .idx_wr_in, .win1_wr_in, .win1_rd_in,
        .win2_wr_in, .win2_rd_in, .from_keypad_in, .wdata_in, .bk_wr_in,
        .bk_data_in, .mon_rd_in, .mon_code_in, .power_fail_in, .nv_rdata_in,
        .nv_addr_out, .nv_we_out, .nv_wdata_out, .rdata_out, .rvalid_out,
        .reject_out, .index_out, .capacity_out, .mon_data_out,
        .backup_armed_out, .restore_busy_out);
    sdaa_nv_model u_nv (.mclk_in, .nv_addr_in(nv_addr_out),
        .nv_we_in(nv_we_out), .nv_wdata_in(nv_wdata_out),
        .nv_rdata_out(nv_rdata_in));
    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        cmp_count++;
        if (seen !== want) begin
            mismatches++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen,
                want);
        end
    endtask
    task automatic tick();
        @(posedge mclk_in);
        #1;
    endtask
    // Codes: 0 index, 1/2 window one write/read, 3/4 window two write/read.
    task automatic acc(input int op, input logic kp, input logic [31:0] v);
        logic ok;
        ok = exp_idx <= SDAA_ADDR_MAX && !(op == 3 && kp);
        tick();
        {idx_wr_in, win1_wr_in, win1_rd_in, win2_wr_in, win2_rd_in} =
            5'h10 >> op;
        from_keypad_in = kp;
        wdata_in = v;
        tick();
        {idx_wr_in, win1_wr_in, win1_rd_in, win2_wr_in, win2_rd_in} = '0;
        if (op != 0) chk(reject_out, !ok);
        if (op != 0) chk(rvalid_out, ok && !op[0]);
        if (op == 0) exp_idx = v[9:0];
        else if (ok) begin
            if (op[0]) exp_mem[exp_idx] = v;
            else chk(rdata_out, exp_mem[exp_idx]);
            if (op != 2 || !kp) exp_idx++;
        end
        chk(index_out, exp_idx);
    endtask
    task automatic bk(input logic [15:0] v);
        tick();
        bk_wr_in = 1;
        bk_data_in = v;
        tick();
        bk_wr_in = 0;
    endtask
    task automatic print_verdict();
        $display("counts: %0d compares, %0d mismatches", cmp_count,
            mismatches);
        if (mismatches == 0 && cmp_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // The whole run needs about 2900 cycles; this allows for slack.
    initial begin
        #400000;
        mismatches++;
        print_verdict();
    end
    initial begin
        for (int i = 0; i < SDAA_RECORDS; i++) exp_mem[i] = 32'h5A00_0000 + i;
        repeat (20) tick();
        nrst_in = 1;
        for (n = 0; restore_busy_out !== 1'b0 && n < 1000; n++) tick();
        chk(restore_busy_out, 0);
        chk(capacity_out, SDAA_RECORDS);
        acc(0, 0, 32'h0000_031D);
        acc(2, 1, '0);
        acc(2, 0, '0);
        acc(4, 1, '0);
        acc(3, 1, 32'h1234_5678);
        acc(1, 1, 32'hCAFE_0001);
        acc(1, 0, 32'hCAFE_0002);
        acc(4, 0, '0);
        $display("test boundary finished");
        for (int i = 0; i < 200; i++) begin
            n = $unsigned($random(seed)) % 5;
            d = $random(seed);
            if (n == 0) d = $unsigned(d) % 806;
            acc(n, 1'($random(seed)), d);
        end
        $display("test random finished");
        for (int i = 0; i < 4; i++) begin
            tick();
            mon_rd_in = 1;
            mon_code_in = (i == 0) ? SDAA_MON_CAPACITY : 8'($random(seed));
            tick();
            mon_rd_in = 0;
            chk(mon_data_out, (mon_code_in == 8'h6D) ? 800 : 0);
        end
        $display("test monitor finished");
        bk(SDAA_BACKUP_GO);
        chk(backup_armed_out, 0);
        bk(SDAA_BACKUP_ARM);
        bk(16'h0007);
        bk(SDAA_BACKUP_GO);
        chk(backup_armed_out, 0);
        bk(SDAA_BACKUP_ARM);
        bk(SDAA_BACKUP_GO);
        chk(backup_armed_out, 1);
        power_fail_in = 1;
        for (n = 0; nv_we_out !== 1'b1 && n < 20; n++) tick();
        for (n = 0; nv_we_out === 1'b1 && n < 900; n++) tick();
        chk(n, SDAA_RECORDS);
        for (int i = 0; i < SDAA_RECORDS; i++) chk(u_nv.mem[i], exp_mem[i]);
        $display("test backup finished");
        power_fail_in = 0;
        nrst_in = 0;
        repeat (2) tick();
        nrst_in = 1;
        exp_idx = '0;
        from_keypad_in = 0;
        win1_rd_in = 1;
        tick();
        win1_rd_in = 0;
        chk(reject_out, 1);
        chk(rvalid_out, 0);
        chk(index_out, 0);
        chk(restore_busy_out, 1);
        for (n = 0; restore_busy_out !== 1'b0 && n < 1000; n++) tick();
        chk(restore_busy_out, 0);
        for (int i = 0; i < 4; i++) acc(4, 1, '0);
        $display("test reload finished");
        print_verdict();
    end
endmodule
